// ---- rtl/csi_master.v ----
// Master three-wire clocked serial channel with an APB register slave.
//
// Overview of operation
// (R1) Duplex master drives clock, shifts data out and in together.
// (R2) Software changes mode, config and rate only while channel disabled.
// (R3) Software waits four clocks after unit enable before prescaler write.
// (R4) Rate divider comes from data register bits 15 to 9.
// (R5) Serial clock between system clock over 4 and over 2*2^11*128.
// (R6) Writing start trigger sets the channel enabled status.
// (R7) Receive-only: dummy write to low data byte starts one frame.
// (R8) Duplex: transmit write to low data byte starts the exchange.
// (R9) Single mode pulses transfer end per frame; software reads byte.
// (R10) Interrupt selects transfer end or buffer empty.
// (R11) Interrupt source select may change during operation.
// (R12) Only receive overrun is detected, via the overrun flag.
// (R13) Data phase: output on first clock edge, or half clock earlier.
// (R14) Clock polarity forward or reversed; 7 or 8 bits, MSB/LSB first.
// (R15) Software stops with stop trigger, then clears unit clock enable.
// (R16) Pins keep their levels after stop until output level rewritten.
// (R17) Flag clear register write clears a remaining overrun flag.
// (R18) Software resumes by disabling outputs, setting levels, re-enabling.
// (R19) Clearing output enable lets level bits drive data directly.
// (R20) New transmit data while buffer full overwrites pending data.
// (R21) Continuous mode chains buffered frames, else stops the clock.
`timescale 1ns/1ns
`include "csi_master_regs.vh"

module csi_master (
    input  wire        REF_CLK_IN,
    input  wire        RESETN_IN,
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [7:0]  PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output reg  [31:0] PRDATA_OUT,
    output wire        PREADY_OUT,
    output wire        PSLVERR_OUT,
    input  wire        SI_IN,
    output reg         SCK_OUT,
    output reg         SO_OUT,
    output reg         DONE_IRQ_OUT
);

    // Software registers.
    reg [5:0]  cfg;
    reg [6:0]  divider;
    reg [3:0]  prescale;
    reg        out_enable;
    reg        unit_enable;
    reg        chan_enabled_status;
    reg        buffer_full_flag;
    reg        overrun_flag;
    reg        rx_valid;
    reg [7:0]  tx_buf;
    reg [7:0]  tx_frame;
    reg [7:0]  rx_data;

    // Shift engine state.
    reg        busy;
    reg [4:0]  step;
    reg [18:0] half_cnt;

    wire       wr_access;
    wire       rd_access;
    wire       setup;
    wire       mapped;
    wire       data_wr;
    wire       start_wr;
    wire       stop_wr;
    wire       clr_wr;
    wire       lvl_wr;
    wire       dap;
    wire [3:0] nbits;
    wire [4:0] last_step;
    wire [2:0] bit_idx;
    wire [2:0] bit_pos;
    wire       tick;
    wire       frame_end;
    wire       launch;
    wire [18:0] half_raw;
    wire [18:0] half_len;

    // Address check, shared by the access decodes and the error answer.
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `OFS_DATA)     || (a == `OFS_CFG)      ||
                        (a == `OFS_PRESCALE) || (a == `OFS_CTRL)     ||
                        (a == `OFS_FLAG_CLR) || (a == `OFS_OUT_LEVEL) ||
                        (a == `OFS_OUT_ENABLE) || (a == `OFS_PERIPH_EN);
        end
    endfunction

    // The slave answers in the first access cycle; read data is captured
    // in the setup cycle so that it comes straight from a flip-flop.
    assign setup       = PSEL_IN & ~PENABLE_IN;
    assign mapped      = is_mapped(PADDR_IN);
    assign PREADY_OUT  = PSEL_IN & PENABLE_IN;
    assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
    assign wr_access   = PSEL_IN & PENABLE_IN & PWRITE_IN & mapped;
    assign rd_access   = PSEL_IN & PENABLE_IN & ~PWRITE_IN & mapped;
    assign data_wr     = wr_access & (PADDR_IN == `OFS_DATA);
    assign start_wr    = wr_access & (PADDR_IN == `OFS_CTRL) &
                         PWDATA_IN[`CTRL_START];
    assign stop_wr     = wr_access & (PADDR_IN == `OFS_CTRL) &
                         PWDATA_IN[`CTRL_STOP];
    assign clr_wr      = wr_access & (PADDR_IN == `OFS_FLAG_CLR) &
                         PWDATA_IN[`CLR_OVERRUN];
    assign lvl_wr      = wr_access & (PADDR_IN == `OFS_OUT_LEVEL);

    // Read data register.
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            PRDATA_OUT <= 32'h00000000;
        end else if (setup && !PWRITE_IN) begin
            if (PADDR_IN == `OFS_DATA) begin
                PRDATA_OUT <= {16'h0000, divider, 1'b0, rx_data};
            end else if (PADDR_IN == `OFS_CFG) begin
                PRDATA_OUT <= {26'h0000000, cfg};
            end else if (PADDR_IN == `OFS_PRESCALE) begin
                PRDATA_OUT <= {28'h0000000, prescale};
            end else if (PADDR_IN == `OFS_CTRL) begin
                PRDATA_OUT <= {27'h0000000, rx_valid, overrun_flag, busy,
                               buffer_full_flag, chan_enabled_status};
            end else if (PADDR_IN == `OFS_OUT_LEVEL) begin
                PRDATA_OUT <= {30'h00000000, SCK_OUT, SO_OUT};
            end else if (PADDR_IN == `OFS_OUT_ENABLE) begin
                PRDATA_OUT <= {31'h00000000, out_enable};
            end else if (PADDR_IN == `OFS_PERIPH_EN) begin
                PRDATA_OUT <= {31'h00000000, unit_enable};
            end else begin
                PRDATA_OUT <= 32'h00000000;
            end
        end
    end

    // Configuration registers. They are not locked while enabled; keeping
    // them still during a frame is left to software.
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            cfg         <= `CFG_RESET;
            divider     <= `DIV_RESET;
            prescale    <= `PRESCALE_RESET;
            out_enable  <= 1'b0;
            unit_enable <= 1'b0;
        end else if (wr_access) begin
            if (PADDR_IN == `OFS_DATA) begin
                divider <= PWDATA_IN[`DIV_HI:`DIV_LO]; // R4
            end else if (PADDR_IN == `OFS_CFG) begin
                cfg <= PWDATA_IN[5:0]; // R11
            end else if (PADDR_IN == `OFS_PRESCALE) begin
                prescale <= (PWDATA_IN[3:0] > `PRESCALE_MAX) ?
                            `PRESCALE_MAX : PWDATA_IN[3:0];
            end else if (PADDR_IN == `OFS_OUT_ENABLE) begin
                out_enable <= PWDATA_IN[0];
            end else if (PADDR_IN == `OFS_PERIPH_EN) begin
                unit_enable <= PWDATA_IN[0];
            end
        end
    end

    // Half period of the serial clock in system clocks, floored at two so
    // the clock never runs faster than a quarter of the system clock.
    assign half_raw = {11'h000, 1'b0, divider} + 19'h00001;
    assign half_len = ((half_raw << prescale) < `MIN_HALF_CLK) ?
                      `MIN_HALF_CLK : (half_raw << prescale); // R5

    // Frame geometry: step counts half periods, one more when the data
    // phase leads the clock by half a period. A stop write freezes the
    // engine in its own cycle, so no edge slips out after the stop.
    assign dap       = cfg[`CFG_DAP];
    assign nbits     = cfg[`CFG_LEN8] ? 4'h8 : 4'h7;
    assign last_step = {nbits, 1'b0} - 5'h01 + {4'h0, dap};
    assign bit_idx   = step[3:1];
    assign bit_pos   = cfg[`CFG_LSB] ? bit_idx :
                       (nbits[2:0] - 3'h1 - bit_idx); // R14
    assign tick      = busy && chan_enabled_status && !stop_wr &&
                       (half_cnt == 19'h00000); // R16
    assign frame_end = tick && (step == last_step);
    assign launch    = chan_enabled_status && buffer_full_flag && !stop_wr &&
                       (!busy || frame_end); // R21

    // Half-period timer.
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            half_cnt <= 19'h00000;
        end else if (launch || tick) begin
            half_cnt <= half_len - 19'h00001;
        end else if (busy) begin
            half_cnt <= half_cnt - 19'h00001;
        end
    end

    // Channel enable, buffer and shift sequencing.
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            chan_enabled_status <= 1'b0;
            buffer_full_flag    <= 1'b0;
            tx_buf              <= 8'h00;
            tx_frame            <= 8'h00;
            busy                <= 1'b0;
            step                <= 5'h00;
        end else begin
            if (!unit_enable || stop_wr) begin
                chan_enabled_status <= 1'b0; // R15
            end else if (start_wr) begin
                chan_enabled_status <= 1'b1; // R6
            end
            // A data write refills the buffer even when already full.
            if (data_wr && chan_enabled_status) begin
                tx_buf           <= PWDATA_IN[7:0]; // R20
                buffer_full_flag <= 1'b1; // R7 R8
            end else if (launch) begin
                buffer_full_flag <= 1'b0;
            end else if (!chan_enabled_status) begin
                buffer_full_flag <= 1'b0;
            end
            // Stopping abandons a frame at once; pins stay where they are.
            if (!chan_enabled_status) begin
                busy <= 1'b0;
            end else if (launch) begin
                busy     <= 1'b1;
                step     <= 5'h00;
                tx_frame <= tx_buf;
            end else if (frame_end) begin
                busy <= 1'b0; // R21
            end else if (tick) begin
                step <= step + 5'h01;
            end
        end
    end

    // Serial clock and data pins. Output shifts on even steps and input
    // is sampled on odd ones; with the data phase set the first bit goes
    // out half a period before the first clock edge.
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            SCK_OUT <= 1'b1;
            SO_OUT  <= 1'b1;
        end else begin
            if (launch && !busy) begin
                SCK_OUT <= ~cfg[`CFG_CKP]; // R14
            end else if (tick && !(dap && step == 5'h00)) begin
                SCK_OUT <= ~SCK_OUT; // R1 R13
            end else if (lvl_wr && !busy) begin
                SCK_OUT <= PWDATA_IN[`LVL_CLOCK]; // R16
            end
            if (tick && !step[0] && step != last_step && out_enable &&
                cfg[`CFG_DUPLEX]) begin
                SO_OUT <= tx_frame[bit_pos]; // R1 R13
            end else if (lvl_wr && !out_enable) begin
                SO_OUT <= PWDATA_IN[`LVL_DATA]; // R19
            end
        end
    end

    // Received data, overrun and the done pulse. A new frame landing on
    // an unread byte keeps the new byte and raises overrun; the set wins
    // over a clear in the same cycle.
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rx_data      <= 8'h00;
            rx_valid     <= 1'b0;
            overrun_flag <= 1'b0;
            DONE_IRQ_OUT <= 1'b0;
        end else begin
            if (tick && step[0]) begin
                rx_data[bit_pos] <= SI_IN; // R1
            end
            if (frame_end && rx_valid) begin
                overrun_flag <= 1'b1; // R12
            end else if (clr_wr) begin
                overrun_flag <= 1'b0; // R17
            end
            if (frame_end) begin
                rx_valid <= 1'b1;
            end else if (rd_access && PADDR_IN == `OFS_DATA) begin
                rx_valid <= 1'b0; // R9
            end
            DONE_IRQ_OUT <= cfg[`CFG_ISS] ? launch : frame_end; // R9 R10
        end
    end

endmodule

// ---- rtl/csi_master_regs.vh ----
// Register offsets, field positions and reset values of the serial channel.
`ifndef CSI_MASTER_REGS_VH
`define CSI_MASTER_REGS_VH

`define OFS_DATA        8'h00
`define OFS_CFG         8'h04
`define OFS_PRESCALE    8'h08
`define OFS_CTRL        8'h0C
`define OFS_FLAG_CLR    8'h10
`define OFS_OUT_LEVEL   8'h14
`define OFS_OUT_ENABLE  8'h18
`define OFS_PERIPH_EN   8'h1C

`define DIV_HI          15
`define DIV_LO          9
`define CFG_ISS         0
`define CFG_DUPLEX      1
`define CFG_DAP         2
`define CFG_CKP         3
`define CFG_LSB         4
`define CFG_LEN8        5
`define CTRL_START      0
`define CTRL_STOP       1
`define CLR_OVERRUN     0
`define LVL_DATA        0
`define LVL_CLOCK       1

`define CFG_RESET       6'h20
`define DIV_RESET       7'h7F
`define PRESCALE_RESET  4'h0
`define PRESCALE_MAX    4'hB
`define MIN_HALF_CLK    19'h00002

`endif

// ---- tb/csi_master_properties.sv ----
// Concurrent checks on the channel's bus answers and serial pins.
`timescale 1ns/1ns
module csi_master_properties (
    input wire        REF_CLK_IN,
    input wire        RESETN_IN,
    input wire        PSEL_IN,
    input wire        PENABLE_IN,
    input wire        PWRITE_IN,
    input wire [7:0]  PADDR_IN,
    input wire [31:0] PWDATA_IN,
    input wire [31:0] PRDATA_OUT,
    input wire        PREADY_OUT,
    input wire        PSLVERR_OUT,
    input wire        SCK_OUT,
    input wire        SO_OUT,
    input wire        DONE_IRQ_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    // Decoded access phase; eight word registers sit from offset zero.
    wire acc = PSEL_IN && PENABLE_IN;
    wire bad = PADDR_IN > 8'h1C || PADDR_IN[1:0] != 2'h0;
    sequence stop_wr;
        acc && PWRITE_IN && PADDR_IN == 8'h0C && PWDATA_IN[1];
    endsequence
    sequence pins_held;
        ($stable(SCK_OUT) && $stable(SO_OUT)) [*3];
    endsequence
    chk_ready_now: assert property (acc |-> PREADY_OUT)
        else $error("no ready in access phase");
    chk_err_unmapped: assert property (acc && bad |-> PSLVERR_OUT)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (acc && !bad |-> !PSLVERR_OUT)
        else $error("mapped access refused");
    chk_read_zero: assert property (acc && !PWRITE_IN && bad
        |-> PRDATA_OUT == 32'h0) else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!(PSEL_IN && !PENABLE_IN && !PWRITE_IN)
        |=> $stable(PRDATA_OUT)) else $error("read data moved");
    chk_done_pulse: assert property (DONE_IRQ_OUT |=> !DONE_IRQ_OUT)
        else $error("done longer than one cycle");
    chk_sck_half: assert property ($changed(SCK_OUT)
        |=> $stable(SCK_OUT))
        else $error("serial clock faster than a quarter");
    chk_stop_hold: assert property (stop_wr |=> pins_held)
        else $error("pins moved after stop");
endmodule

bind csi_master csi_master_properties u_props (.REF_CLK_IN, .RESETN_IN,
    .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT,
    .PREADY_OUT, .PSLVERR_OUT, .SCK_OUT, .SO_OUT, .DONE_IRQ_OUT);

// ---- tb/csi_slave_model.sv ----
// Behavioural serial slave that answers the channel's frames.
`timescale 1ns/1ns
module csi_slave_model (
    input  wire       sck,
    input  wire       mosi,
    input  wire [7:0] tx_byte,
    output reg        miso = 1'b1,
    output reg  [7:0] rx_byte = 8'h00
);
    reg [7:0] shift = 8'h00;
    reg [2:0] cnt = 3'h0;
    reg       armed = 1'b0;
    // Falling edge shifts out and loads the byte at a frame's first edge.
    // Rising edge samples; after the last one the line shows the inverse,
    // so a released line never passes for held data. The first falling
    // edge arms the model, so the clock's rise out of reset is not data.
    always @(posedge sck or negedge sck) begin
        if (sck === 1'b0) begin
            armed <= 1'b1;
            miso  <= (cnt == 3'h0) ? tx_byte[7] : shift[7];
            shift <= (cnt == 3'h0) ? {tx_byte[6:0], 1'b0} : {shift[6:0], 1'b0};
        end else if (sck === 1'b1 && armed) begin
            rx_byte <= {rx_byte[6:0], mosi};
            cnt     <= cnt + 3'h1;
            if (cnt == 3'h7)
                miso <= ~miso;
        end
    end
endmodule

// ---- tb/csi_master_tb.sv ----
// Register-level bench for the serial channel with a slave model.
`timescale 1ns/1ns
module csi_master_tb;
    logic        clk;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  slave_tx = 8'h00;
    wire  [31:0] prdata;
    wire         pready, pslverr, sck, mosi, miso, irq;
    wire  [7:0]  slave_rx;
    int          n_mismatch = 0;
    int          checked = 0;
    int          n_irq = 0;
    int          n_irq0;
    logic        hold;

    csi_master u_dut (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .SI_IN(miso), .SCK_OUT(sck), .SO_OUT(mosi),
        .DONE_IRQ_OUT(irq));
    csi_slave_model u_slave (.sck(sck), .mosi(mosi), .tx_byte(slave_tx),
        .miso(miso), .rx_byte(slave_rx));

    // Counts done pulses, so chained frames can be checked afterwards.
    always @(posedge clk) begin
        if (irq === 1'b1)
            n_irq <= n_irq + 1;
    end

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("compares %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One transfer; the request stands until ready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        // The slave has no wait states: ready in the first access cycle.
        chk("wait_states", n, 1);
    endtask

    task automatic rchk(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask

    // Starts a frame with divider 1 and times the first clock half period.
    task automatic run_frame(input logic [7:0] tx);
        int n, t0, t1;
        logic prev, got;
        apb(1'b1, 8'h00, {16'h0, 7'h01, 1'b0, tx});
        t0 = 0;
        t1 = 0;
        got = 1'b0;
        prev = sck;
        for (n = 1; n < 400 && !got; n++) begin
            @(negedge clk);
            if (sck !== prev && t0 != 0 && t1 == 0)
                t1 = n;
            if (sck !== prev && t0 == 0)
                t0 = n;
            prev = sck;
            got = (irq === 1'b1);
        end
        // Hand the bus back on a rising edge, never on the falling one.
        @(posedge clk);
        chk("done", got, 1'b1);
        chk("half_period", t1 - t0, 4);
    endtask

    initial begin
        #100000;
        n_mismatch++;
        conclude;
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk("cfg_rst", 8'h04, 32'h20);
        rchk("pre_rst", 8'h08, 32'h0);
        rchk("oe_rst", 8'h18, 32'h0);
        rchk("pen_rst", 8'h1C, 32'h0);
        rchk("unmapped", 8'h40, 32'h0);
        chk("slverr", err, 1'b1);
        $display("test reset values done");
        apb(1'b1, 8'h1C, 32'h1);
        repeat (4) @(posedge clk);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h04, 32'h22);
        apb(1'b1, 8'h14, 32'h2);
        chk("so_level", mosi, 1'b0);
        apb(1'b1, 8'h14, 32'h3);
        apb(1'b1, 8'h18, 32'h1);
        apb(1'b1, 8'h0C, 32'h1);
        rchk("enabled", 8'h0C, 32'h1);
        slave_tx = 8'hA5;
        run_frame(8'h3C);
        rchk("rx_valid", 8'h0C, 32'h11);
        rchk("duplex_rx", 8'h00, 32'h2A5);
        chk("slave_rx", slave_rx, 8'h3C);
        apb(1'b1, 8'h0C, 32'h2);
        rchk("stopped", 8'h0C, 32'h0);
        $display("test duplex frame done");
        apb(1'b1, 8'h04, 32'h33);
        apb(1'b1, 8'h0C, 32'h1);
        slave_tx = 8'h01;
        n_irq0 = n_irq;
        apb(1'b1, 8'h00, {16'h0, 7'h01, 1'b0, 8'h12});
        apb(1'b1, 8'h00, {16'h0, 7'h01, 1'b0, 8'h34});
        apb(1'b1, 8'h00, {16'h0, 7'h01, 1'b0, 8'h56});
        repeat (160) @(posedge clk);
        chk("empty_irqs", n_irq - n_irq0, 2);
        chk("chain_tx", slave_rx, 8'h6A);
        rchk("chain_flags", 8'h0C, 32'h19);
        rchk("lsb_rx", 8'h00, 32'h280);
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b1, 8'h0C, 32'h2);
        $display("test continuous frames done");
        apb(1'b1, 8'h04, 32'h20);
        apb(1'b1, 8'h0C, 32'h1);
        slave_tx = 8'h5A;
        run_frame(8'hFF);
        rchk("recv_rx", 8'h00, 32'h25A);
        slave_tx = 8'hC3;
        run_frame(8'h00);
        run_frame(8'h00);
        rchk("overrun", 8'h0C, 32'h19);
        apb(1'b1, 8'h10, 32'h1);
        rchk("ovr_clear", 8'h0C, 32'h11);
        rchk("ovr_data", 8'h00, 32'h2C3);
        apb(1'b1, 8'h00, {16'h0, 7'h01, 1'b0, 8'h00});
        repeat (10) @(posedge clk);
        apb(1'b1, 8'h0C, 32'h2);
        hold = sck;
        repeat (20) @(posedge clk);
        chk("sck_hold", sck, hold);
        rchk("abort", 8'h0C, 32'h0);
        apb(1'b1, 8'h1C, 32'h0);
        $display("test receive and overrun done");
        conclude;
    end
endmodule
